// ### include/bfm_pkg.sv
package bfm_pkg;
    // data width of both queues and both mailboxes
    localparam int BFM_DATA_W = 36;
    // queue depth default; 1024, 4096 or 16384 are legal
    localparam int BFM_DEPTH_DEFAULT = 1024;
    // width of every offset register, wide enough for the deepest queue
    localparam int BFM_OFS_W = 14;
    // offset presets chosen by the two select inputs at a queue reset release
    localparam logic [13:0] BFM_PRESET_HH = 14'h0040;
    localparam logic [13:0] BFM_PRESET_HL = 14'h0010;
    localparam logic [13:0] BFM_PRESET_LH = 14'h0008;
    // offset value after device reset
    localparam logic [13:0] BFM_OFS_RESET = 14'h0040;
    // parallel programming index of each offset register
    localparam logic [1:0] BFM_IDX_AB_AE = 2'h0;
    localparam logic [1:0] BFM_IDX_AB_AF = 2'h1;
    localparam logic [1:0] BFM_IDX_BA_AE = 2'h2;
    localparam logic [1:0] BFM_IDX_BA_AF = 2'h3;
    // queue indices
    localparam int BFM_Q_AB = 0;
    localparam int BFM_Q_BA = 1;
    // depth of the staging buffer in the port A write path
    localparam int BFM_STAGE_DEPTH = 4;
    // flag bit positions in a synchronised flag vector
    localparam int BFM_F_FULL = 0;
    localparam int BFM_F_AF = 1;
    localparam int BFM_F_AE = 2;
    localparam int BFM_F_NE = 3;
    // mailbox full flag value after reset (high means empty)
    localparam logic BFM_MAIL_FULL_N_RESET = 1'b1;
endpackage

// ### src/bfm_top.sv
`timescale 1ns/1ps

// small staging queue with valid and ready on both sides
module bfm_stage_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 4
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] slot_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic push;
    logic pop;

    // honest full and empty from pointers with a wrap bit
    assign in_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
    assign out_valid_o = wp_r != rp_r;
    assign out_data_o = slot_r[rp_r[AW-1:0]];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // pointer update
    always_ff @(posedge clock_i) begin
        if (!resetn_i || clear_i) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= rp_r + 1'b1;
            end
        end
    end

    // storage
    always_ff @(posedge clock_i) begin
        if (push) begin
            slot_r[wp_r[AW-1:0]] <= in_data_i;
        end
    end
endmodule

module bfm_top import bfm_pkg::*; #(
    parameter int DEPTH = BFM_DEPTH_DEFAULT
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic port_a_clk_i,
    input wire logic port_a_select_n_i,
    input wire logic port_a_dir_i,
    input wire logic port_a_en_i,
    input wire logic port_a_mail_sel_i,
    input wire logic [BFM_DATA_W-1:0] port_a_data_i,
    output logic [BFM_DATA_W-1:0] port_a_data_o,
    output logic port_a_data_oe_o,
    input wire logic port_b_clk_i,
    input wire logic port_b_select_n_i,
    input wire logic port_b_dir_i,
    input wire logic port_b_en_i,
    input wire logic port_b_mail_sel_i,
    input wire logic [BFM_DATA_W-1:0] port_b_data_i,
    output logic [BFM_DATA_W-1:0] port_b_data_o,
    output logic port_b_data_oe_o,
    input wire logic ab_master_reset_n_i,
    input wire logic ba_master_reset_n_i,
    input wire logic offset_preset_sel0_i,
    input wire logic offset_preset_sel1_i,
    input wire logic offset_prog_we_i,
    input wire logic [1:0] offset_prog_idx_i,
    input wire logic offset_ser_shift_i,
    input wire logic offset_ser_bit_i,
    input wire logic first_word_fall_through_i,
    input wire logic ab_rewind_n_i,
    input wire logic ba_rewind_n_i,
    output logic ab_full_ready_o,
    output logic ab_almost_full_n_o,
    output logic ab_empty_ready_o,
    output logic ab_almost_empty_n_o,
    output logic ba_full_ready_o,
    output logic ba_almost_full_n_o,
    output logic ba_empty_ready_o,
    output logic ba_almost_empty_n_o,
    output logic ab_mail_full_n_o,
    output logic ba_mail_full_n_o,
    output logic ab_stage_ready_o
);
    localparam int PW = $clog2(DEPTH) + 1;
    localparam int AW = PW - 1;

    logic [BFM_DATA_W-1:0] mem_r [2][DEPTH];
    logic [PW-1:0] wptr_r [2];
    logic [PW-1:0] rptr_r [2];
    logic [PW-1:0] count [2];
    logic [BFM_DATA_W-1:0] out_r [2];
    logic out_valid_r [2];
    logic [BFM_DATA_W-1:0] mail_r [2];
    logic mail_full_n_r [2];
    logic [BFM_OFS_W-1:0] ae_off_r [2];
    logic [BFM_OFS_W-1:0] af_off_r [2];
    logic [3:0] flag_raw [2];
    logic [3:0] flag_s1_r [2];
    logic [3:0] flag_s2_r [2];
    logic mrst_prev_r [2];
    logic mrst_n [2];
    logic rewind_n [2];
    logic qclr [2];
    logic a_clk_prev_r;
    logic b_clk_prev_r;
    logic a_edge;
    logic b_edge;
    logic a_wr;
    logic a_rd;
    logic b_wr;
    logic b_rd;
    logic wr_req [2];
    logic [BFM_DATA_W-1:0] wr_data [2];
    logic rd_req [2];
    logic wr_take [2];
    logic rd_take [2];
    logic mb_wr [2];
    logic mb_rd [2];
    logic [BFM_DATA_W-1:0] mb_data [2];
    logic stage_push;
    logic stage_valid;
    logic [BFM_DATA_W-1:0] stage_data;
    logic prog_mode;

    // stored words: pointer distance, output register excluded
    function automatic logic [PW-1:0] fill_of(input logic [PW-1:0] wp, input logic [PW-1:0] rp);
        fill_of = wp - rp;
    endfunction

    // port clock edges seen on the system clock
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            a_clk_prev_r <= 1'b0;
            b_clk_prev_r <= 1'b0;
        end else begin
            a_clk_prev_r <= port_a_clk_i;
            b_clk_prev_r <= port_b_clk_i;
        end
    end
    assign a_edge = port_a_clk_i & ~a_clk_prev_r;
    assign b_edge = port_b_clk_i & ~b_clk_prev_r;

    // port decode; port B direction is inverted
    assign a_wr = ~port_a_select_n_i & port_a_dir_i & port_a_en_i & a_edge;
    assign a_rd = ~port_a_select_n_i & ~port_a_dir_i & port_a_en_i & a_edge;
    assign b_wr = ~port_b_select_n_i & ~port_b_dir_i & port_b_en_i & b_edge;
    assign b_rd = ~port_b_select_n_i & port_b_dir_i & port_b_en_i & b_edge;

    // queue and mailbox requests per direction
    assign stage_push = a_wr & ~port_a_mail_sel_i & flag_s2_r[BFM_Q_AB][BFM_F_FULL];
    assign wr_req[BFM_Q_AB] = stage_valid;
    assign wr_data[BFM_Q_AB] = stage_data;
    assign wr_req[BFM_Q_BA] = b_wr & ~port_b_mail_sel_i & flag_s2_r[BFM_Q_BA][BFM_F_FULL];
    assign wr_data[BFM_Q_BA] = port_b_data_i;
    assign rd_req[BFM_Q_AB] = b_rd & ~port_b_mail_sel_i;
    assign rd_req[BFM_Q_BA] = a_rd & ~port_a_mail_sel_i;
    assign mb_wr[BFM_Q_AB] = a_wr & port_a_mail_sel_i;
    assign mb_wr[BFM_Q_BA] = b_wr & port_b_mail_sel_i;
    assign mb_data[BFM_Q_AB] = port_a_data_i;
    assign mb_data[BFM_Q_BA] = port_b_data_i;
    assign mb_rd[BFM_Q_AB] = b_rd & port_b_mail_sel_i;
    assign mb_rd[BFM_Q_BA] = a_rd & port_a_mail_sel_i;
    assign mrst_n[BFM_Q_AB] = ab_master_reset_n_i;
    assign mrst_n[BFM_Q_BA] = ba_master_reset_n_i;
    assign rewind_n[BFM_Q_AB] = ab_rewind_n_i;
    assign rewind_n[BFM_Q_BA] = ba_rewind_n_i;

    // staging buffer between port A and the ab queue; full queue stalls it
    bfm_stage_fifo #(
        .WIDTH(BFM_DATA_W),
        .DEPTH(BFM_STAGE_DEPTH)
    ) u_stage (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .clear_i(~ab_master_reset_n_i),
        .in_valid_i(stage_push),
        .in_ready_o(ab_stage_ready_o),
        .in_data_i(port_a_data_i),
        .out_valid_o(stage_valid),
        .out_ready_i(wr_take[BFM_Q_AB]),
        .out_data_o(stage_data)
    );

    // per-queue take conditions and raw flags
    always_comb begin
        for (int q = 0; q < 2; q++) begin
            qclr[q] = ~resetn_i | ~mrst_n[q];
            count[q] = fill_of(wptr_r[q], rptr_r[q]);
            // a write needs a free location, a read a stored word
            wr_take[q] = wr_req[q] & (count[q] != PW'(DEPTH)) & ~qclr[q];
            if (first_word_fall_through_i) begin
                // fall through when the output register is free or being read
                rd_take[q] = (count[q] != '0) & flag_s2_r[q][BFM_F_NE]
                    & (~out_valid_r[q] | rd_req[q]);
            end else begin
                rd_take[q] = rd_req[q] & (count[q] != '0) & flag_s2_r[q][BFM_F_NE];
            end
            flag_raw[q][BFM_F_FULL] = count[q] != PW'(DEPTH);
            // almost full: low from depth minus offset upward
            flag_raw[q][BFM_F_AF] = (16'(count[q]) + 16'(af_off_r[q]))
                < 16'(DEPTH);
            flag_raw[q][BFM_F_AE] = 16'(count[q]) > 16'(ae_off_r[q]);
            flag_raw[q][BFM_F_NE] = count[q] != '0;
        end
    end

    // two flip-flop stages for every flag
    always_ff @(posedge clock_i) begin
        for (int q = 0; q < 2; q++) begin
            if (qclr[q]) begin
                flag_s1_r[q] <= 4'h3;
                flag_s2_r[q] <= 4'h3;
            end else begin
                flag_s1_r[q] <= flag_raw[q];
                flag_s2_r[q] <= flag_s1_r[q];
            end
        end
    end

    // write pointers
    always_ff @(posedge clock_i) begin
        for (int q = 0; q < 2; q++) begin
            if (qclr[q]) begin
                wptr_r[q] <= '0;
            end else if (wr_take[q]) begin
                wptr_r[q] <= wptr_r[q] + 1'b1;
            end
        end
    end

    // queue memories
    always_ff @(posedge clock_i) begin
        for (int q = 0; q < 2; q++) begin
            if (wr_take[q]) begin
                mem_r[q][wptr_r[q][AW-1:0]] <= wr_data[q];
            end
        end
    end

    // read pointers; rewind returns to the first location in standard mode
    always_ff @(posedge clock_i) begin
        for (int q = 0; q < 2; q++) begin
            if (qclr[q]) begin
                rptr_r[q] <= '0;
            end else if (!rewind_n[q] && !first_word_fall_through_i) begin
                rptr_r[q] <= '0;
            end else if (rd_take[q]) begin
                rptr_r[q] <= rptr_r[q] + 1'b1;
            end
        end
    end

    // output registers and the output-ready state
    always_ff @(posedge clock_i) begin
        for (int q = 0; q < 2; q++) begin
            if (qclr[q]) begin
                out_r[q] <= '0;
                out_valid_r[q] <= 1'b0;
            end else if (rd_take[q]) begin
                out_r[q] <= mem_r[q][rptr_r[q][AW-1:0]];
                out_valid_r[q] <= 1'b1;
            end else if (rd_req[q] && first_word_fall_through_i) begin
                out_valid_r[q] <= 1'b0;
            end
        end
    end

    // mailbox registers; a read never alters the data
    always_ff @(posedge clock_i) begin
        for (int q = 0; q < 2; q++) begin
            if (!resetn_i) begin
                mail_r[q] <= '0;
            end else if (mb_wr[q] && mail_full_n_r[q]) begin
                mail_r[q] <= mb_data[q];
            end
        end
    end

    // mailbox flags: a write drives low, a far-side read drives high
    always_ff @(posedge clock_i) begin
        for (int q = 0; q < 2; q++) begin
            if (!resetn_i) begin
                mail_full_n_r[q] <= BFM_MAIL_FULL_N_RESET;
            end else if (mb_wr[q] && mail_full_n_r[q]) begin
                mail_full_n_r[q] <= 1'b0;
            end else if (mb_rd[q]) begin
                mail_full_n_r[q] <= 1'b1;
            end
        end
    end

    // master reset release edge detection
    always_ff @(posedge clock_i) begin
        for (int q = 0; q < 2; q++) begin
            if (!resetn_i) begin
                mrst_prev_r[q] <= 1'b1;
            end else begin
                mrst_prev_r[q] <= mrst_n[q];
            end
        end
    end

    // programming allowed only with both preset selects low
    assign prog_mode = ~offset_preset_sel0_i & ~offset_preset_sel1_i;

    // offset registers: preset, parallel from port A, or serial chain
    always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
            for (int q = 0; q < 2; q++) begin
                ae_off_r[q] <= BFM_OFS_RESET;
                af_off_r[q] <= BFM_OFS_RESET;
            end
        end else if (prog_mode && offset_ser_shift_i) begin
            // serial chain order: ab_ae, ab_af, ba_ae, ba_af; bit enters ba_af lsb
            {ae_off_r[0], af_off_r[0], ae_off_r[1], af_off_r[1]} <= {ae_off_r[0][BFM_OFS_W-2:0],
                af_off_r[0], ae_off_r[1], af_off_r[1], offset_ser_bit_i};
        end else if (prog_mode && offset_prog_we_i) begin
            unique case (offset_prog_idx_i)
                BFM_IDX_AB_AE: ae_off_r[0] <= port_a_data_i[BFM_OFS_W-1:0];
                BFM_IDX_AB_AF: af_off_r[0] <= port_a_data_i[BFM_OFS_W-1:0];
                BFM_IDX_BA_AE: ae_off_r[1] <= port_a_data_i[BFM_OFS_W-1:0];
                BFM_IDX_BA_AF: af_off_r[1] <= port_a_data_i[BFM_OFS_W-1:0];
            endcase
        end else begin
            for (int q = 0; q < 2; q++) begin
                if (mrst_n[q] && !mrst_prev_r[q] && !prog_mode) begin
                    if (offset_preset_sel1_i && offset_preset_sel0_i) begin
                        ae_off_r[q] <= BFM_PRESET_HH;
                        af_off_r[q] <= BFM_PRESET_HH;
                    end else if (offset_preset_sel1_i) begin
                        ae_off_r[q] <= BFM_PRESET_HL;
                        af_off_r[q] <= BFM_PRESET_HL;
                    end else begin
                        ae_off_r[q] <= BFM_PRESET_LH;
                        af_off_r[q] <= BFM_PRESET_LH;
                    end
                end
            end
        end
    end

    // bus drivers: mailbox or queue output register
    assign port_a_data_oe_o = ~port_a_select_n_i & ~port_a_dir_i;
    assign port_b_data_oe_o = ~port_b_select_n_i & port_b_dir_i;
    assign port_a_data_o = port_a_mail_sel_i ? mail_r[BFM_Q_BA] : out_r[BFM_Q_BA];
    assign port_b_data_o = port_b_mail_sel_i ? mail_r[BFM_Q_AB] : out_r[BFM_Q_AB];

    // flag outputs; only the empty/ready flags follow the timing mode, full/ready is the full flag in both modes
    assign ab_full_ready_o = flag_s2_r[BFM_Q_AB][BFM_F_FULL];
    assign ab_almost_full_n_o = flag_s2_r[BFM_Q_AB][BFM_F_AF];
    assign ab_almost_empty_n_o = flag_s2_r[BFM_Q_AB][BFM_F_AE];
    assign ab_empty_ready_o = first_word_fall_through_i ? out_valid_r[BFM_Q_AB]
        : flag_s2_r[BFM_Q_AB][BFM_F_NE];
    assign ba_full_ready_o = flag_s2_r[BFM_Q_BA][BFM_F_FULL];
    assign ba_almost_full_n_o = flag_s2_r[BFM_Q_BA][BFM_F_AF];
    assign ba_almost_empty_n_o = flag_s2_r[BFM_Q_BA][BFM_F_AE];
    assign ba_empty_ready_o = first_word_fall_through_i ? out_valid_r[BFM_Q_BA]
        : flag_s2_r[BFM_Q_BA][BFM_F_NE];
    assign ab_mail_full_n_o = mail_full_n_r[BFM_Q_AB];
    assign ba_mail_full_n_o = mail_full_n_r[BFM_Q_BA];
endmodule

// ### bench/bfm_port_master.sv
`timescale 1ns/1ps
// bus master for one port; the dir level WR_LEVEL selects a write
module bfm_port_master #(
    parameter logic WR_LEVEL = 1'b1
) (
    input wire logic clock_i,
    input wire logic [35:0] rdata_i,
    output logic pclk_o = 1'b0,
    output logic select_n_o = 1'b1,
    output logic dir_o = 1'b0,
    output logic en_o = 1'b0,
    output logic mail_sel_o = 1'b0,
    output logic [35:0] wdata_o = 36'h0
);
    // park the port with enable off; the released data line keeps changing
    task automatic hold(input logic sel_n, input logic dir, input logic mail);
        @(posedge clock_i);
        en_o <= 1'b0;
        select_n_o <= sel_n;
        dir_o <= dir;
        mail_sel_o <= mail;
        wdata_o <= ~wdata_o;
    endtask

    // one transfer: port clock high for one cycle, answer taken after that edge
    task automatic op(input logic wr, input logic mail, input logic [35:0] d,
                      output logic [35:0] q);
        @(posedge clock_i);
        pclk_o <= 1'b1;
        select_n_o <= 1'b0;
        dir_o <= wr ? WR_LEVEL : ~WR_LEVEL;
        en_o <= 1'b1;
        mail_sel_o <= mail;
        wdata_o <= d;
        @(posedge clock_i);
        pclk_o <= 1'b0;
        en_o <= 1'b0;
        wdata_o <= ~d;
        #1 q = rdata_i;
    endtask
endmodule

// ### bench/bfm_top_chk.sv
`timescale 1ns/1ps
// port decode and mailbox handshake watcher
module bfm_top_chk import bfm_pkg::*; (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic port_a_clk_i,
    input wire logic port_a_select_n_i,
    input wire logic port_a_dir_i,
    input wire logic port_a_en_i,
    input wire logic port_a_mail_sel_i,
    input wire logic [BFM_DATA_W-1:0] port_a_data_i,
    input wire logic port_a_data_oe_o,
    input wire logic port_b_clk_i,
    input wire logic port_b_select_n_i,
    input wire logic port_b_dir_i,
    input wire logic port_b_en_i,
    input wire logic port_b_mail_sel_i,
    input wire logic [BFM_DATA_W-1:0] port_b_data_o,
    input wire logic port_b_data_oe_o,
    input wire logic first_word_fall_through_i,
    input wire logic ab_full_ready_o,
    input wire logic ab_almost_full_n_o,
    input wire logic ab_empty_ready_o,
    input wire logic ab_almost_empty_n_o,
    input wire logic ba_full_ready_o,
    input wire logic ba_almost_full_n_o,
    input wire logic ab_mail_full_n_o
);
    logic a_clk_q;
    logic b_clk_q;
    // previous port clock samples for edge detection
    always_ff @(posedge clock_i) begin
        a_clk_q <= port_a_clk_i;
        b_clk_q <= port_b_clk_i;
    end
    // mailbox write on A and mailbox read on B
    wire a_mail_wr = port_a_clk_i & ~a_clk_q & ~port_a_select_n_i & port_a_dir_i
        & port_a_en_i & port_a_mail_sel_i;
    wire b_mail_rd = port_b_clk_i & ~b_clk_q & ~port_b_select_n_i & port_b_dir_i
        & port_b_en_i & port_b_mail_sel_i;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence mail_put_s;
        a_mail_wr && ab_mail_full_n_o;
    endsequence
    sequence mail_take_s;
        b_mail_rd && !a_mail_wr;
    endsequence

    oe_a_decode_a: assert property (
        port_a_data_oe_o == (!port_a_select_n_i && !port_a_dir_i))
        else $error("port A drive enable wrong");
    oe_b_decode_a: assert property (
        port_b_data_oe_o == (!port_b_select_n_i && port_b_dir_i))
        else $error("port B drive enable wrong");
    mail_clear_a: assert property (mail_put_s |=> !ab_mail_full_n_o)
        else $error("mail flag not low after write");
    mail_hold_a: assert property (
        !ab_mail_full_n_o && !b_mail_rd |=> !ab_mail_full_n_o)
        else $error("mail flag rose without a read");
    mail_release_a: assert property (mail_take_s |=> ab_mail_full_n_o)
        else $error("mail flag not high after read");
    mail_load_a: assert property (
        mail_put_s ##1 port_b_mail_sel_i |-> port_b_data_o == $past(port_a_data_i))
        else $error("mailbox data not stored");
    mail_keep_a: assert property (
        port_b_mail_sel_i && $past(port_b_mail_sel_i) && !$past(a_mail_wr)
        && $past(resetn_i) |-> $stable(port_b_data_o))
        else $error("mailbox data changed without write");
    ab_full_af_a: assert property (!ab_full_ready_o |-> !ab_almost_full_n_o)
        else $error("full without almost full");
    ba_full_af_a: assert property (!ba_full_ready_o |-> !ba_almost_full_n_o)
        else $error("full without almost full");
    empty_ae_a: assert property (
        !ab_empty_ready_o && !first_word_fall_through_i |-> !ab_almost_empty_n_o)
        else $error("empty without almost empty");
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import bfm_pkg::*;
    localparam int DEPTH = 1024;
    localparam logic [55:0] SER_CHAIN = {14'h0008, 14'h0008, 14'h0000, 14'h0008};
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ab_mrst_n = 1'b1;
    logic ba_mrst_n = 1'b1;
    logic sel0 = 1'b1;
    logic sel1 = 1'b1;
    logic ab_rew_n = 1'b1;
    logic first_word_fall_through = 1'b0, ba_rew_n = 1'b1, ser_shift = 1'b0, ser_bit = 1'b0;
    logic a_clk, a_sel_n, a_dir, a_en, a_mail, b_clk, b_sel_n, b_dir, b_en, b_mail;
    logic [BFM_DATA_W-1:0] a_wd, a_rd, b_wd, b_rd, q;
    logic ab_full, ab_af, ab_er, ab_ae, ba_full, ba_af, ba_er, ba_ae;
    logic ab_mf, ba_mf, a_oe, b_oe, stage_rdy;
    // rows: select_n, dir, expected drive enable of A, of B
    logic [3:0] rows [4] = '{4'h2, 4'h5, 4'h8, 4'hC};
    int failures = 0;
    int checks = 0;

    always #5 clock_i = ~clock_i;

    // resolved data buses: the design drives while its enable is high
    wire [BFM_DATA_W-1:0] a_bus = a_oe ? a_rd : a_wd;
    wire [BFM_DATA_W-1:0] b_bus = b_oe ? b_rd : b_wd;

    bfm_port_master #(.WR_LEVEL(1'b1)) port_a_master (.clock_i(clock_i), .rdata_i(a_rd),
        .pclk_o(a_clk), .select_n_o(a_sel_n), .dir_o(a_dir), .en_o(a_en),
        .mail_sel_o(a_mail), .wdata_o(a_wd));
    bfm_port_master #(.WR_LEVEL(1'b0)) port_b_master (.clock_i(clock_i), .rdata_i(b_rd),
        .pclk_o(b_clk), .select_n_o(b_sel_n), .dir_o(b_dir), .en_o(b_en),
        .mail_sel_o(b_mail), .wdata_o(b_wd));
    bfm_top #(.DEPTH(DEPTH)) bfm_top_inst (.clock_i(clock_i), .resetn_i(resetn_i),
        .port_a_clk_i(a_clk), .port_a_select_n_i(a_sel_n), .port_a_dir_i(a_dir),
        .port_a_en_i(a_en), .port_a_mail_sel_i(a_mail), .port_a_data_i(a_bus),
        .port_a_data_o(a_rd), .port_a_data_oe_o(a_oe), .port_b_clk_i(b_clk),
        .port_b_select_n_i(b_sel_n), .port_b_dir_i(b_dir), .port_b_en_i(b_en),
        .port_b_mail_sel_i(b_mail), .port_b_data_i(b_bus), .port_b_data_o(b_rd),
        .port_b_data_oe_o(b_oe), .ab_master_reset_n_i(ab_mrst_n),
        .ba_master_reset_n_i(ba_mrst_n), .offset_preset_sel0_i(sel0),
        .offset_preset_sel1_i(sel1), .offset_prog_we_i(1'b0), .offset_prog_idx_i(2'h0),
        .offset_ser_shift_i(ser_shift), .offset_ser_bit_i(ser_bit),
        .first_word_fall_through_i(first_word_fall_through), .ab_rewind_n_i(ab_rew_n), .ba_rewind_n_i(ba_rew_n),
        .ab_full_ready_o(ab_full), .ab_almost_full_n_o(ab_af), .ab_empty_ready_o(ab_er),
        .ab_almost_empty_n_o(ab_ae), .ba_full_ready_o(ba_full),
        .ba_almost_full_n_o(ba_af), .ba_empty_ready_o(ba_er), .ba_almost_empty_n_o(ba_ae),
        .ab_mail_full_n_o(ab_mf), .ba_mail_full_n_o(ba_mf), .ab_stage_ready_o(stage_rdy));

    // compare and count
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    function automatic logic [35:0] word(input int i);
        return 36'hA_5000_0000 + 36'(i);
    endfunction

    // hang guard
    initial begin
        #1_000_000;
        failures++;
        print_verdict();
    end

    // main sequence
    initial begin
        idle(3);
        #1 check(36'({ab_full, ab_af, ab_ae, ab_er, ab_mf, ba_mf}), 36'h33);
        @(posedge clock_i);
        resetn_i <= 1'b1;
        sel1 <= 1'b0;
        ba_mrst_n <= 1'b0;
        idle(2);
        ba_mrst_n <= 1'b1; // select 01 loads offset 8
        idle(2);
        $display("test reset done");
        foreach (rows[i]) begin
            port_a_master.hold(rows[i][3], rows[i][2], 1'b0);
            port_b_master.hold(rows[i][3], rows[i][2], 1'b0);
            #1 check(36'(a_oe), 36'(rows[i][1]));
            check(36'(b_oe), 36'(rows[i][0]));
        end
        $display("test decode done");
        port_b_master.hold(1'b0, 1'b1, 1'b1);
        port_a_master.op(1'b1, 1'b1, 36'h9_1234_5678, q);
        port_a_master.op(1'b1, 1'b1, 36'h0_DEAD_BEEF, q);
        check(36'(ab_mf), 36'h0);
        port_b_master.op(1'b0, 1'b1, 36'h0, q);
        check(q, 36'h9_1234_5678);
        port_b_master.op(1'b0, 1'b1, 36'h0, q);
        check(q, 36'h9_1234_5678);
        check(36'(ab_mf), 36'h1);
        port_b_master.op(1'b1, 1'b1, 36'h3_0F0F_0F0F, q);
        port_a_master.op(1'b0, 1'b1, 36'h0, q);
        check(q, 36'h3_0F0F_0F0F);
        idle(1);
        #1 check(36'(ba_mf), 36'h1);
        $display("test mailbox done");
        // fill the B-to-A queue, watching flags at the offset boundaries
        for (int i = 0; i < DEPTH; i++) begin
            port_b_master.op(1'b1, 1'b0, word(i), q);
            idle(6);
            #1;
            if (i == 0) check(36'({ba_er, ba_ae}), 36'h2);
            if (i == 7) check(36'(ba_ae), 36'h0);
            if (i == 9) check(36'(ba_ae), 36'h1);
            if (i == DEPTH - 11) check(36'(ba_af), 36'h1);
            if (i == DEPTH - 9) check(36'(ba_af), 36'h0);
            if (i == DEPTH - 2) check(36'(ba_full), 36'h1);
        end
        check(36'({ba_full, ba_af}), 36'h0);
        port_b_master.op(1'b1, 1'b0, 36'hF_FFFF_FFFF, q); // refused while full
        for (int i = 0; i < DEPTH; i++) begin
            if (i < 2 || DEPTH - i <= 3) idle(6);
            port_a_master.op(1'b0, 1'b0, 36'h0, q);
            check(q, word(i));
            if (i == 1 || i == 7 || i == 8) begin
                idle(6);
                #1 check(36'({ba_full, ba_af}), (i == 8) ? 36'h3 : 36'h2);
            end
        end
        idle(6);
        port_a_master.op(1'b0, 1'b0, 36'h0, q);
        check(q, word(DEPTH - 1));
        check(36'({ba_er, ba_ae}), 36'h0);
        $display("test queue done");
        // replay after rewind, then new data behind it
        for (int i = 0; i < 3; i++) port_a_master.op(1'b1, 1'b0, word(100 + i), q);
        idle(8);
        for (int i = 0; i < 3; i++) begin
            port_b_master.op(1'b0, 1'b0, 36'h0, q);
            check(q, word(100 + i));
        end
        @(posedge clock_i);
        ab_rew_n <= 1'b0; // reader enable stays off around the pulse
        idle(2);
        ab_rew_n <= 1'b1;
        idle(8);
        #1 check(36'(ab_er), 36'h1);
        port_a_master.op(1'b1, 1'b0, word(103), q);
        idle(8);
        for (int i = 0; i < 4; i++) begin
            port_b_master.op(1'b0, 1'b0, 36'h0, q);
            check(q, word(100 + i));
        end
        $display("test rewind done");
        @(posedge clock_i);
        ab_mrst_n <= 1'b0;
        idle(2);
        ab_mrst_n <= 1'b1;
        idle(4);
        #1 check(36'({ab_er, ab_ae}), 36'h0);
        for (int i = 0; i < DEPTH; i++) port_a_master.op(1'b1, 1'b0, word(i), q);
        idle(8);
        #1 check(36'({ab_full, ab_af, stage_rdy}), 36'h1);
        port_b_master.op(1'b0, 1'b0, 36'h0, q);
        check(q, word(0));
        idle(8);
        #1 check(36'(ab_full), 36'h1);
        $display("test staging done");
        @(posedge clock_i);
        first_word_fall_through <= 1'b1;
        ba_mrst_n <= 1'b0;
        idle(2);
        ba_mrst_n <= 1'b1;
        idle(4);
        port_b_master.op(1'b1, 1'b0, word(7), q);
        idle(6);
        #1 check(a_rd, word(7));
        check(36'({ba_er, ba_ae}), 36'h2);
        port_a_master.op(1'b0, 1'b0, 36'h0, q);
        check(q, word(7));
        @(posedge clock_i);
        ba_rew_n <= 1'b0;
        idle(2);
        ba_rew_n <= 1'b1;
        idle(6);
        #1 check(36'(ba_er), 36'h0);
        @(posedge clock_i);
        sel0 <= 1'b0;
        for (int i = 55; i >= 0; i--) begin
            @(posedge clock_i);
            ser_shift <= 1'b1;
            ser_bit <= SER_CHAIN[i];
        end
        @(posedge clock_i);
        ser_shift <= 1'b0;
        sel0 <= 1'b1;
        port_b_master.op(1'b1, 1'b0, word(8), q);
        port_b_master.op(1'b1, 1'b0, word(9), q);
        idle(6);
        #1 check(36'(ba_ae), 36'h1);
        $display("test first_word_fall_through done");
        port_a_master.op(1'b1, 1'b1, 36'h1, q);
        @(posedge clock_i);
        resetn_i <= 1'b0;
        idle(2);
        #1 check(36'({ab_full, ab_af, ab_ae, ab_er, ab_mf, ba_mf}), 36'h33);
        @(posedge clock_i);
        resetn_i <= 1'b1;
        idle(2);
        $display("test second reset done");
        print_verdict();
    end
endmodule

bind bfm_top bfm_top_chk bfm_top_chk_inst (.*);
